/* File: asx_exec.sv */
`timescale 1ns/1ps
module asx_exec
  import asx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire asx_req_t i_req,
  input wire logic [PAGE_W-1:0] i_pc_page,
  input wire logic [DW-1:0] i_tbl_ptr,
  input wire logic [ROM_DW-1:0] i_rom_data,
  input wire logic i_ld_en,
  input wire logic [MEM_AW-1:0] i_ld_addr,
  input wire logic [DW-1:0] i_ld_data,
  input wire logic [MEM_AW-1:0] i_peek_addr,
  output logic o_ready,
  output logic o_done,
  output logic o_discard,
  output logic o_rom_rd,
  output logic [ROM_AW-1:0] o_rom_addr,
  output logic [DW-1:0] o_acc,
  output asx_flags_t o_flags,
  output logic [DW-1:0] o_tbl_high,
  output logic [DW-1:0] o_peek_data
);
  asx_state_t state_q;
  asx_state_t state_d;
  logic [DW-1:0] mem_q [MEM_DEPTH];
  logic [DW-1:0] acc_q;
  asx_flags_t flags_q;
  logic [DW-1:0] table_high_latch_q;
  logic ready_q;
  logic done_q;
  logic discard_q;
  logic rom_rd_q;
  logic [ROM_AW-1:0] rom_addr_q;
  logic [MEM_AW-1:0] tbl_dst_q;
  logic [DW-1:0] peek_q;

  logic take;
  logic [DW-1:0] mval;
  logic [DW-1:0] opnd;
  logic [DW-1:0] sub_res;
  asx_flags_t sub_flags;
  logic [DW-1:0] xor_res;
  logic [DW-1:0] nib_res;
  logic skip;
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [DW-1:0] mem_wd;

  assign take = i_req_valid && ready_q;

  always_comb begin
    mval = MEM_RST;
    if (i_req.addr < MEM_DEPTH[MEM_AW:0]) begin
      mval = mem_q[i_req.addr];
    end
  end

  assign opnd = (i_req.op == OP_MINUS_IMM) ? i_req.imm : mval;

  asx_sub u_sub (
    .i_a(acc_q),
    .i_b(opnd),
    .o_res(sub_res),
    .o_flags(sub_flags)
  );

  assign xor_res = acc_q ^ ((i_req.op == OP_XOR_IMM) ? i_req.imm : mval);
  assign nib_res = {mval[3:0], mval[7:4]};

  always_comb begin
    skip = 1'b0;
    unique case (i_req.op)
      OP_SKZ_BYTE: skip = (mval == '0);
      OP_LD_SKZ: skip = (mval == '0);
      OP_SKZ_BIT: skip = ~mval[i_req.bit_sel];
      default: skip = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take && skip) begin
          state_d = ST_DUMMY;
        end else if (take && (i_req.op == OP_TBL_CUR || i_req.op == OP_TBL_LAST)) begin
          state_d = ST_TABLE;
        end
      end
      ST_DUMMY: state_d = ST_IDLE;
      ST_TABLE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == ST_IDLE);
    end
  end

  // skip handling and completion
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      discard_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      discard_q <= take && skip;
      done_q <= (take && !skip && i_req.op != OP_TBL_CUR && i_req.op != OP_TBL_LAST)
                || state_q == ST_DUMMY || state_q == ST_TABLE;
    end
  end

  // program memory request for table reads
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rom_rd_q <= 1'b0;
      rom_addr_q <= '0;
      tbl_dst_q <= '0;
    end else begin
      rom_rd_q <= 1'b0;
      if (take && i_req.op == OP_TBL_CUR) begin
        rom_rd_q <= 1'b1;
        rom_addr_q <= {i_pc_page, i_tbl_ptr};
        tbl_dst_q <= i_req.addr;
      end else if (take && i_req.op == OP_TBL_LAST) begin
        rom_rd_q <= 1'b1;
        rom_addr_q <= {LAST_PAGE, i_tbl_ptr};
        tbl_dst_q <= i_req.addr;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      table_high_latch_q <= TABLE_HIGH_LATCH_RST;
    end else if (state_q == ST_TABLE) begin
      table_high_latch_q <= i_rom_data[ROM_DW-1:DW];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= ACC_RST;
    end else if (take) begin
      unique case (i_req.op)
        OP_MINUS_ACC: acc_q <= sub_res;
        OP_MINUS_IMM: acc_q <= sub_res;
        OP_NIB_ACC: acc_q <= nib_res;
        OP_LD_SKZ: acc_q <= mval;
        OP_XOR_ACC: acc_q <= xor_res;
        OP_XOR_IMM: acc_q <= xor_res;
        default: acc_q <= acc_q;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= FLAGS_RST;
    end else if (take) begin
      unique case (i_req.op)
        OP_MINUS_ACC, OP_MINUS_MEM, OP_MINUS_IMM: flags_q <= sub_flags;
        OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM: flags_q.z <= (xor_res == '0);
        default: flags_q <= flags_q;
      endcase
    end
  end

  always_comb begin
    mem_we = 1'b0;
    mem_wa = i_req.addr;
    mem_wd = sub_res;
    if (state_q == ST_TABLE) begin
      mem_we = 1'b1;
      mem_wa = tbl_dst_q;
      mem_wd = i_rom_data[DW-1:0];
    end else if (take && i_req.op == OP_MINUS_MEM) begin
      mem_we = 1'b1;
    end else if (take && i_req.op == OP_NIB_MEM) begin
      mem_we = 1'b1;
      mem_wd = nib_res;
    end else if (take && i_req.op == OP_XOR_MEM) begin
      mem_we = 1'b1;
      mem_wd = xor_res;
    end else if (i_ld_en) begin
      mem_we = 1'b1;
      mem_wa = i_ld_addr;
      mem_wd = i_ld_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < MEM_DEPTH; k++) begin
        mem_q[k] <= MEM_RST;
      end
    end else if (mem_we && mem_wa < MEM_DEPTH[MEM_AW:0]) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      peek_q <= MEM_RST;
    end else if (i_peek_addr < MEM_DEPTH[MEM_AW:0]) begin
      peek_q <= mem_q[i_peek_addr];
    end else begin
      peek_q <= MEM_RST;
    end
  end

  assign o_ready = ready_q;
  assign o_done = done_q;
  assign o_discard = discard_q;
  assign o_rom_rd = rom_rd_q;
  assign o_rom_addr = rom_addr_q;
  assign o_acc = acc_q;
  assign o_flags = flags_q;
  assign o_tbl_high = table_high_latch_q;
  assign o_peek_data = peek_q;
endmodule

/* File: asx_pkg.sv */
// Behaviour
// - minus_to_acc stores acc plus inverted byte plus one, updating four arithmetic flags.
// - minus_to_memory does the same subtraction but writes the addressed byte.
// - immediate subtraction takes acc minus immediate into acc, four flags updated.
// - nibble_exchange_in_place swaps the byte's nibbles in memory, flags untouched.
// - nibble_exchange_to_acc puts the swapped byte in acc, memory and flags untouched.
// - skip_on_zero byte: zero discards prefetch plus dummy cycle, two cycles, else one.
// - load_and_skip_on_zero copies byte to acc, skips when zero, flags untouched.
// - skip_on_zero bit form tests one bit, skips when that bit is zero.
// - table_fetch_current_page splits current-page word: low to memory, high to latch.
// - table_fetch_last_page does the same split from the last program page.
// - exclusive_or_to_acc with memory stores acc xor byte, only zero flag changes.
// - exclusive_or_to_memory stores byte xor acc in memory, only zero flag changes.
// - immediate exclusive_or_to_acc stores acc xor immediate, only zero flag changes.
package asx_pkg;
  localparam int DW = 8;
  localparam int MEM_DEPTH = 224;
  localparam int MEM_AW = 8;
  localparam int ROM_AW = 15;
  localparam int ROM_DW = 16;
  localparam int PAGE_W = 7;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 7'h5f;
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [DW-1:0] TABLE_HIGH_LATCH_RST = 8'h00;
  localparam logic [DW-1:0] MEM_RST = 8'h00;
  localparam int HALF_BIT = 4;

  typedef enum logic [3:0] {
    OP_MINUS_ACC   = 4'h0,
    OP_MINUS_MEM   = 4'h1,
    OP_MINUS_IMM   = 4'h2,
    OP_NIB_MEM     = 4'h3,
    OP_NIB_ACC     = 4'h4,
    OP_SKZ_BYTE    = 4'h5,
    OP_LD_SKZ      = 4'h6,
    OP_SKZ_BIT     = 4'h7,
    OP_TBL_CUR     = 4'h8,
    OP_TBL_LAST    = 4'h9,
    OP_XOR_ACC     = 4'ha,
    OP_XOR_MEM     = 4'hb,
    OP_XOR_IMM     = 4'hc
  } asx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DUMMY = 2'b01,
    ST_TABLE = 2'b10
  } asx_state_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } asx_flags_t;

  typedef struct packed {
    asx_op_t op;
    logic [MEM_AW-1:0] addr;
    logic [DW-1:0] imm;
    logic [2:0] bit_sel;
  } asx_req_t;

  localparam asx_flags_t FLAGS_RST = '{ov: 1'b0, z: 1'b0, ac: 1'b0, c: 1'b0};
endpackage

/* File: asx_sub.sv */
`timescale 1ns/1ps
module asx_sub
  import asx_pkg::*;
(
  input wire logic [DW-1:0] i_a,
  input wire logic [DW-1:0] i_b,
  output logic [DW-1:0] o_res,
  output asx_flags_t o_flags
);
  logic [DW:0] full;
  logic [HALF_BIT:0] low;
  logic [DW-1:0] nb;

  always_comb begin
    nb = ~i_b;
    full = {1'b0, i_a} + {1'b0, nb} + {{DW{1'b0}}, 1'b1};
    low = {1'b0, i_a[HALF_BIT-1:0]} + {1'b0, nb[HALF_BIT-1:0]} + {{HALF_BIT{1'b0}}, 1'b1};
    o_res = full[DW-1:0];
    o_flags.c = full[DW];
    o_flags.z = (full[DW-1:0] == '0);
    o_flags.ac = low[HALF_BIT];
    o_flags.ov = (i_a[DW-1] == nb[DW-1]) && (full[DW-1] != i_a[DW-1]);
  end
endmodule

/* File: asx_exec_assertions.sv */
`timescale 1ns/1ps
module asx_exec_assertions
  import asx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire asx_req_t i_req,
  input wire logic [PAGE_W-1:0] i_pc_page,
  input wire logic [DW-1:0] i_tbl_ptr,
  input wire logic [ROM_DW-1:0] i_rom_data,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_discard,
  input wire logic o_rom_rd,
  input wire logic [ROM_AW-1:0] o_rom_addr,
  input wire logic [DW-1:0] o_acc,
  input wire asx_flags_t o_flags,
  input wire logic [DW-1:0] o_tbl_high
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic tk;
  assign tk = i_req_valid && o_ready;
  AST_PLAIN_DONE:
    assert property (tk && (i_req.op <= OP_NIB_ACC || i_req.op >= OP_XOR_ACC)
      |=> o_done && !o_discard) else $error("plain op not done in one cycle");
  AST_SUB_IMM:
    assert property (tk && i_req.op == OP_MINUS_IMM |=> {o_flags.c, o_acc} ==
      {1'b0, $past(o_acc)} + {1'b0, ~$past(i_req.imm)} + 9'h1) else $error("sub imm wrong");
  AST_XOR_IMM:
    assert property (tk && i_req.op == OP_XOR_IMM |=> o_acc == ($past(o_acc) ^ $past(i_req.imm))
      && o_flags.z == (o_acc == 8'h00) && $stable(o_flags.ov) && $stable(o_flags.ac)
      && $stable(o_flags.c)) else $error("xor imm wrong");
  AST_FLAGS_KEEP:
    assert property (tk && i_req.op >= OP_NIB_MEM && i_req.op <= OP_TBL_LAST
      |=> $stable(o_flags)) else $error("flags changed");
  AST_SKIP_SEQ:
    assert property (o_discard |-> !o_ready ##1 (o_done && o_ready))
      else $error("skip timing wrong");
  AST_TBL_CUR:
    assert property (tk && i_req.op == OP_TBL_CUR |=> o_rom_rd && !o_ready
      && o_rom_addr == {$past(i_pc_page), $past(i_tbl_ptr)}) else $error("table cur addr");
  AST_TBL_LAST:
    assert property (tk && i_req.op == OP_TBL_LAST |=> o_rom_rd
      && o_rom_addr == {LAST_PAGE, $past(i_tbl_ptr)}) else $error("table last addr");
  AST_TBL_HIGH:
    assert property (o_rom_rd |=> o_done && {o_tbl_high, 8'h00} == ($past(i_rom_data) & 16'hff00))
      else $error("table high wrong");
  COV_SKIP: cover property (o_discard);
  COV_TBL: cover property (o_rom_rd);
  COV_SUB: cover property (tk && i_req.op == OP_MINUS_ACC);
endmodule

bind asx_exec asx_exec_assertions u_asx_exec_assertions (.i_mclk, .i_rst, .i_req_valid, .i_req,
  .i_pc_page, .i_tbl_ptr, .i_rom_data, .o_ready, .o_done, .o_discard, .o_rom_rd, .o_rom_addr,
  .o_acc, .o_flags, .o_tbl_high);

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import asx_pkg::*;
  logic i_mclk, i_rst, i_req_valid, i_ld_en, o_ready, o_done, o_discard, o_rom_rd;
  asx_req_t i_req;
  asx_flags_t o_flags;
  logic [PAGE_W-1:0] i_pc_page;
  logic [MEM_AW-1:0] i_ld_addr, i_peek_addr;
  logic [DW-1:0] i_tbl_ptr, i_ld_data, o_acc, o_tbl_high, o_peek_data;
  logic [ROM_DW-1:0] i_rom_data;
  logic [ROM_AW-1:0] o_rom_addr;
  int num_errors = 0;
  int total_checks = 0;

  asx_exec u_asx_exec (.i_mclk, .i_rst, .i_req_valid, .i_req, .i_pc_page, .i_tbl_ptr, .i_rom_data,
    .i_ld_en, .i_ld_addr, .i_ld_data, .i_peek_addr, .o_ready, .o_done, .o_discard, .o_rom_rd,
    .o_rom_addr, .o_acc, .o_flags, .o_tbl_high, .o_peek_data);

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  task automatic chk(logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic load(logic [7:0] a, logic [7:0] d);
    @(negedge i_mclk);
    i_ld_en = 1'b1;
    i_ld_addr = a;
    i_ld_data = d;
    @(negedge i_mclk);
    i_ld_en = 1'b0;
  endtask

  task automatic peek(logic [7:0] a, logic [7:0] e);
    @(negedge i_mclk);
    i_peek_addr = a;
    @(negedge i_mclk);
    chk(o_peek_data, e);
  endtask

  task automatic run(asx_op_t op, logic [7:0] a, logic [7:0] x, logic [2:0] b, int cyc, logic dsc);
    int n;
    logic d;
    logic r;
    n = 0;
    d = 1'b0;
    r = 1'b0;
    @(negedge i_mclk);
    i_req = '{op: op, addr: a, imm: x, bit_sel: b};
    i_req_valid = 1'b1;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    while (o_done !== 1'b1 && n < 8) begin
      d = d | o_discard;
      r = r | o_rom_rd;
      n++;
      @(negedge i_mclk);
    end
    chk(16'(n + 1), 16'(cyc));
    chk({15'h0, d}, {15'h0, dsc});
    chk({15'h0, r}, {15'h0, (op == OP_TBL_CUR) || (op == OP_TBL_LAST)});
  endtask

  initial begin
    repeat (3000) @(posedge i_mclk);
    num_errors++;
    close_out();
  end

  initial begin
    i_rst = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_pc_page = 7'h12;
    i_tbl_ptr = 8'h34;
    i_rom_data = 16'hbe42;
    i_ld_en = 1'b0;
    i_ld_addr = 8'h00;
    i_ld_data = 8'h00;
    i_peek_addr = 8'h00;
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    load(8'h05, 8'h3c);
    load(8'h07, 8'h81);
    run(OP_XOR_IMM, 8'h00, 8'h5a, 3'h0, 1, 1'b0);
    chk(o_acc, 8'h5a);
    run(OP_MINUS_ACC, 8'h07, 8'h00, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'hd90a);
    run(OP_MINUS_MEM, 8'h05, 8'h00, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'hd901);
    peek(8'h05, 8'h9d);
    run(OP_MINUS_IMM, 8'h00, 8'hd9, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'h0007);
    $display("test subtract done");
    run(OP_NIB_MEM, 8'h05, 8'h00, 3'h0, 1, 1'b0);
    peek(8'h05, 8'hd9);
    run(OP_NIB_ACC, 8'h05, 8'h00, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'h9d07);
    peek(8'h05, 8'hd9);
    $display("test nibble done");
    run(OP_SKZ_BYTE, 8'h06, 8'h00, 3'h0, 2, 1'b1);
    run(OP_SKZ_BYTE, 8'h07, 8'h00, 3'h0, 1, 1'b0);
    run(OP_SKZ_BIT, 8'h07, 8'h00, 3'h1, 2, 1'b1);
    run(OP_SKZ_BIT, 8'h07, 8'h00, 3'h7, 1, 1'b0);
    run(OP_LD_SKZ, 8'h06, 8'h00, 3'h0, 2, 1'b1);
    chk({o_acc, 4'h0, o_flags}, 16'h0007);
    run(OP_LD_SKZ, 8'h07, 8'h00, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'h8107);
    $display("test skip done");
    run(OP_TBL_CUR, 8'h08, 8'h00, 3'h0, 2, 1'b0);
    chk({o_tbl_high, 4'h0, o_flags}, 16'hbe07);
    chk({1'b0, o_rom_addr}, {1'b0, i_pc_page, i_tbl_ptr});
    peek(8'h08, 8'h42);
    i_rom_data = 16'h7e01;
    run(OP_TBL_LAST, 8'h09, 8'h00, 3'h0, 2, 1'b0);
    chk({o_tbl_high, 4'h0, o_flags}, 16'h7e07);
    chk({1'b0, o_rom_addr}, {1'b0, LAST_PAGE, i_tbl_ptr});
    peek(8'h09, 8'h01);
    $display("test table done");
    run(OP_XOR_MEM, 8'h05, 8'h00, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'h8103);
    peek(8'h05, 8'h58);
    run(OP_XOR_ACC, 8'h07, 8'h00, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'h0007);
    $display("test xor done");
    @(negedge i_mclk);
    i_rst = 1'b1;
    @(negedge i_mclk);
    chk({o_tbl_high, 3'h0, o_ready, o_flags}, 16'h0000);
    i_rst = 1'b0;
    @(negedge i_mclk);
    chk({15'h0, o_ready}, 16'h0001);
    run(OP_MINUS_IMM, 8'h00, 8'h01, 3'h0, 1, 1'b0);
    chk({o_acc, 4'h0, o_flags}, 16'hff00);
    $display("test reset done");
    close_out();
  end
endmodule
